//--- design/ette_pkg.sv
package ette_pkg;

  // Register byte offsets
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] ENAB_OFS = 32'h0000_0004;
  localparam logic [31:0] VBASE_OFS = 32'h0000_0008;
  localparam logic [31:0] STAT_OFS = 32'h0000_000c;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] ENAB_RST = 16'h0000;
  localparam logic [31:0] VBASE_RST = 32'h0000_0000;

  // Control register: only the skip bit is implemented
  localparam int CTRL_SKIP_BIT = 4;
  localparam logic [7:0] CTRL_MASK = 8'h10;

  // Activation source numbers (enable bit index and vector slot)
  localparam int SRC_TX = 8;
  localparam int SRC_RX = 9;
  localparam logic [3:0] SRC_TX_ID = 4'h8;
  localparam logic [3:0] SRC_RX_ID = 4'h9;

  // Mode word field positions
  localparam int MODE_A_KIND_LSB = 6;
  localparam int MODE_A_SIZE_LSB = 4;
  localparam int MODE_A_SRC_STEP_LSB = 2;
  localparam int MODE_B_IRQ_EACH_BIT = 5;
  localparam int MODE_B_DST_STEP_LSB = 2;

  // Transfer modes
  localparam logic [1:0] KIND_NORMAL = 2'h0;
  localparam logic [1:0] KIND_REPEAT = 2'h1;
  localparam logic [1:0] KIND_BLOCK = 2'h2;

  // Transfer information words in memory
  localparam logic [1:0] INFO_LAST = 2'h3;
  localparam logic [1:0] INFO_FIRST_BACK = 2'h1;

  typedef struct packed {
    logic [7:0] mode_a;
    logic [7:0] mode_b;
    logic [31:0] src_ptr;
    logic [31:0] dst_ptr;
    logic [15:0] count_a;
    logic [15:0] count_b;
  } ette_info_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ette_mem_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_VEC = 3'b001,
    ST_INFO = 3'b010,
    ST_READ = 3'b011,
    ST_WRITE = 3'b100,
    ST_BACK = 3'b101,
    ST_END = 3'b110
  } ette_state_e;

endpackage : ette_pkg

//--- design/ette_top.sv
// How it works
// - Normal mode: 16-bit count decrements per transfer
// - Normal count zero: clear enable, interrupt CPU
// - Count one is one; zero means 65536
// - Repeat: low byte counts, reloads from high
// - Repeat byte zero gives 256 transfers
// - Block: low byte counts units, reloads
// - Block size zero means 256 units
// - Block: second count per block, zero ends
// - Second count ignored in normal, repeat
// - Separate 32-bit source and destination pointers
// - Transfer information invisible to CPU registers
// - One enable bit per source starts transfers
// - Control bit skips rereading transfer information
// - Vector table address from 32-bit base
// - Transmit-empty request moves RAM to FIFO
// - Receive-full request moves FIFO to RAM
// - Transmit increments source, receive increments destination
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
module ette_top
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial port activation requests
  input wire logic tx_empty_req,
  input wire logic rx_full_req,
  output logic tx_req_ack,
  output logic rx_req_ack,
  // CPU completion interrupts
  output logic irq_tx_done,
  output logic irq_rx_done,
  // Memory master port
  output ette_pkg::ette_mem_s mem,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  import ette_pkg::*;

  function automatic logic [3:0] reg_decode(input logic [31:0] a);
    reg_decode = {a == STAT_OFS, a == VBASE_OFS, a == ENAB_OFS, a == CTRL_OFS};
  endfunction : reg_decode

  function automatic logic [31:0] ptr_step(input logic [31:0] p, input logic [1:0] am,
                                           input logic [1:0] sz);
    logic [31:0] n;
    n = 32'h1 << sz;
    if (!am[1])
      ptr_step = p;
    else if (am[0])
      ptr_step = p - n;
    else
      ptr_step = p + n;
  endfunction : ptr_step

  function automatic ette_mem_s mem_cmd(input logic we, input logic [1:0] sz,
                                        input logic [31:0] a, input logic [31:0] d);
    mem_cmd.req = 1'b1;
    mem_cmd.we = we;
    mem_cmd.size = sz;
    mem_cmd.addr = a;
    mem_cmd.wdata = d;
  endfunction : mem_cmd

  // AHB address phase capture
  logic [3:0] wr_sel_reg;
  logic [31:0] hrdata_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [15:0] enab_reg;
  logic [15:0] enab_next;
  logic [31:0] vbase_reg;
  logic [31:0] vbase_next;

  // Engine state
  ette_state_e st_reg;
  ette_state_e st_next;
  ette_info_s info_reg;
  ette_info_s info_next;
  ette_mem_s mem_reg;
  ette_mem_s mem_next;
  logic [1:0] idx_reg;
  logic [1:0] idx_next;
  logic [3:0] src_reg;
  logic [3:0] src_next;
  logic [31:0] data_reg;
  logic [31:0] data_next;
  logic [31:0] iptr_reg;
  logic [31:0] iptr_next;
  logic fin_reg;
  logic fin_next;
  logic cache_vld_reg;
  logic cache_vld_next;
  logic [3:0] last_src_reg;
  logic [3:0] last_src_next;
  logic [15:0] hw_clr;
  logic tx_ack_next;
  logic rx_ack_next;
  logic irq_tx_next;
  logic irq_rx_next;
  logic tx_ack_reg;
  logic rx_ack_reg;
  logic irq_tx_reg;
  logic irq_rx_reg;

  wire ahb_take = hsel & hready & htrans[1];
  wire [3:0] rd_sel = reg_decode(haddr);
  wire busy = st_reg != ST_IDLE;
  wire [31:0] stat_word = {24'h0, 1'b0, st_reg, 3'b000, busy};

  // Register file; reads see a write finishing in the same cycle
  assign ctrl_next = wr_sel_reg[0] ? (hwdata[7:0] & CTRL_MASK) : ctrl_reg;
  assign enab_next = (wr_sel_reg[1] ? hwdata[15:0] : enab_reg) & ~hw_clr;
  assign vbase_next = wr_sel_reg[2] ? hwdata : vbase_reg;
  wire [31:0] rd_word = ({32{rd_sel[0]}} & {24'h0, ctrl_next}) |
                        ({32{rd_sel[1]}} & {16'h0, enab_next}) |
                        ({32{rd_sel[2]}} & vbase_next) |
                        ({32{rd_sel[3]}} & stat_word);

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Activation: receive first, a full receive FIFO loses data
  wire tx_act = tx_empty_req & enab_reg[SRC_TX];
  wire rx_act = rx_full_req & enab_reg[SRC_RX];
  wire [3:0] act_src = rx_act ? SRC_RX_ID : SRC_TX_ID;
  wire skip_ok = ctrl_reg[CTRL_SKIP_BIT] & cache_vld_reg & (last_src_reg == act_src);

  // Mode fields and counter arithmetic
  wire [1:0] xfer_kind = info_reg.mode_a[MODE_A_KIND_LSB +: 2];
  wire [1:0] sz = info_reg.mode_a[MODE_A_SIZE_LSB +: 2];
  wire [1:0] src_step = info_reg.mode_a[MODE_A_SRC_STEP_LSB +: 2];
  wire [1:0] dst_step = info_reg.mode_b[MODE_B_DST_STEP_LSB +: 2];
  wire irq_each = info_reg.mode_b[MODE_B_IRQ_EACH_BIT];
  wire [15:0] cnt_a_dec = info_reg.count_a - 16'h0001;
  wire [7:0] run_dec = info_reg.count_a[7:0] - 8'h01;
  wire [15:0] cnt_b_dec = info_reg.count_b - 16'h0001;
  wire run_zero = run_dec == 8'h00;
  wire [7:0] run_new = run_zero ? info_reg.count_a[15:8] : run_dec;
  wire mem_done = mem_reg.req & mem_ack;
  wire [31:0] vec_addr = vbase_reg + {26'h0, src_reg, 2'b00};
  wire [31:0] word_addr = iptr_reg + {28'h0, idx_reg, 2'b00};
  wire [31:0] back_word = (idx_reg == 2'h1) ? info_reg.src_ptr :
                          (idx_reg == 2'h2) ? info_reg.dst_ptr :
                          {info_reg.count_a, info_reg.count_b};

  always_comb
  begin
    st_next = st_reg;
    info_next = info_reg;
    mem_next = mem_reg;
    idx_next = idx_reg;
    src_next = src_reg;
    data_next = data_reg;
    iptr_next = iptr_reg;
    fin_next = fin_reg;
    cache_vld_next = cache_vld_reg & ~wr_sel_reg[0] & ~wr_sel_reg[2];
    last_src_next = last_src_reg;
    hw_clr = 16'h0000;
    tx_ack_next = 1'b0;
    rx_ack_next = 1'b0;
    irq_tx_next = 1'b0;
    irq_rx_next = 1'b0;
    if (mem_done)
      mem_next.req = 1'b0;
    case (st_reg)
      ST_IDLE:
      begin
        fin_next = 1'b0;
        if (tx_act | rx_act)
        begin
          src_next = act_src;
          idx_next = 2'h0;
          st_next = skip_ok ? ST_READ : ST_VEC;
        end
      end
      ST_VEC:
      begin
        if (!mem_reg.req)
          mem_next = mem_cmd(1'b0, 2'h2, vec_addr, 32'h0);
        else if (mem_ack)
        begin
          iptr_next = mem_rdata;
          st_next = ST_INFO;
        end
      end
      ST_INFO:
      begin
        // Transfer information lives in memory; info_reg keeps a working copy
        if (!mem_reg.req)
          mem_next = mem_cmd(1'b0, 2'h2, word_addr, 32'h0);
        else if (mem_ack)
        begin
          case (idx_reg)
            2'h0:
            begin
              info_next.mode_a = mem_rdata[31:24];
              info_next.mode_b = mem_rdata[23:16];
            end
            2'h1: info_next.src_ptr = mem_rdata;
            2'h2: info_next.dst_ptr = mem_rdata;
            default:
            begin
              info_next.count_a = mem_rdata[31:16];
              info_next.count_b = mem_rdata[15:0];
            end
          endcase
          idx_next = idx_reg + 2'h1;
          if (idx_reg == INFO_LAST)
            st_next = ST_READ;
        end
      end
      ST_READ:
      begin
        if (!mem_reg.req)
          mem_next = mem_cmd(1'b0, sz, info_reg.src_ptr, 32'h0);
        else if (mem_ack)
        begin
          data_next = mem_rdata;
          st_next = ST_WRITE;
        end
      end
      ST_WRITE:
      begin
        if (!mem_reg.req)
          mem_next = mem_cmd(1'b1, sz, info_reg.dst_ptr, data_reg);
        else if (mem_ack)
        begin
          info_next.src_ptr = ptr_step(info_reg.src_ptr, src_step, sz);
          info_next.dst_ptr = ptr_step(info_reg.dst_ptr, dst_step, sz);
          idx_next = INFO_FIRST_BACK;
          st_next = ST_BACK;
          case (xfer_kind)
            KIND_NORMAL:
            begin
              info_next.count_a = cnt_a_dec;
              fin_next = cnt_a_dec == 16'h0000;
            end
            KIND_REPEAT:
              // Repeat mode never completes on its own
              info_next.count_a[7:0] = run_new;
            KIND_BLOCK:
            begin
              info_next.count_a[7:0] = run_new;
              if (run_zero)
              begin
                info_next.count_b = cnt_b_dec;
                fin_next = cnt_b_dec == 16'h0000;
              end
              else
                st_next = ST_READ;
            end
            default:
              info_next.count_a = cnt_a_dec;
          endcase
        end
      end
      ST_BACK:
      begin
        // Updated pointers and counts go back before the next request
        if (!mem_reg.req)
          mem_next = mem_cmd(1'b1, 2'h2, word_addr, back_word);
        else if (mem_ack)
        begin
          idx_next = idx_reg + 2'h1;
          if (idx_reg == INFO_LAST)
            st_next = ST_END;
        end
      end
      ST_END:
      begin
        tx_ack_next = src_reg == SRC_TX_ID;
        rx_ack_next = src_reg == SRC_RX_ID;
        if (fin_reg)
          hw_clr[src_reg] = 1'b1;
        irq_tx_next = (fin_reg | irq_each) & (src_reg == SRC_TX_ID);
        irq_rx_next = (fin_reg | irq_each) & (src_reg == SRC_RX_ID);
        // A write to ctrl or base landing now still invalidates
        cache_vld_next = ~wr_sel_reg[0] & ~wr_sel_reg[2];
        last_src_next = src_reg;
        st_next = ST_IDLE;
      end
      default:
        st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_sel_reg <= 4'h0;
      hrdata_reg <= 32'h0000_0000;
      ctrl_reg <= CTRL_RST;
      enab_reg <= ENAB_RST;
      vbase_reg <= VBASE_RST;
    end
    else
    begin
      wr_sel_reg <= (ahb_take & hwrite) ? rd_sel : 4'h0;
      if (ahb_take & ~hwrite)
        hrdata_reg <= rd_word;
      ctrl_reg <= ctrl_next;
      enab_reg <= enab_next;
      vbase_reg <= vbase_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= ST_IDLE;
      info_reg <= '0;
      mem_reg <= '0;
      idx_reg <= 2'h0;
      src_reg <= 4'h0;
      data_reg <= 32'h0000_0000;
      iptr_reg <= 32'h0000_0000;
      fin_reg <= 1'b0;
      cache_vld_reg <= 1'b0;
      last_src_reg <= 4'h0;
      tx_ack_reg <= 1'b0;
      rx_ack_reg <= 1'b0;
      irq_tx_reg <= 1'b0;
      irq_rx_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      info_reg <= info_next;
      mem_reg <= mem_next;
      idx_reg <= idx_next;
      src_reg <= src_next;
      data_reg <= data_next;
      iptr_reg <= iptr_next;
      fin_reg <= fin_next;
      cache_vld_reg <= cache_vld_next;
      last_src_reg <= last_src_next;
      tx_ack_reg <= tx_ack_next;
      rx_ack_reg <= rx_ack_next;
      irq_tx_reg <= irq_tx_next;
      irq_rx_reg <= irq_rx_next;
    end
  end

  assign mem = mem_reg;
  assign tx_req_ack = tx_ack_reg;
  assign rx_req_ack = rx_ack_reg;
  assign irq_tx_done = irq_tx_reg;
  assign irq_rx_done = irq_rx_reg;

endmodule : ette_top

//--- verification/ette_sva.sv
module ette_sva
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Observed outputs
  input wire logic tx_req_ack,
  input wire logic rx_req_ack,
  input wire logic irq_tx_done,
  input wire logic irq_rx_done,
  input wire ette_pkg::ette_mem_s mem,
  input wire logic mem_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  import ette_pkg::*;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_tx_pulse;
    tx_req_ack |=> !tx_req_ack;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx ack too long");
  property p_rx_pulse;
    rx_req_ack |=> !rx_req_ack;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx ack too long");
  property p_irq_tx;
    irq_tx_done |-> tx_req_ack ##1 !irq_tx_done;
  endproperty
  a_irq_tx: assert property (p_irq_tx) else $error("tx irq without unit");
  property p_irq_rx;
    irq_rx_done |-> rx_req_ack ##1 !irq_rx_done;
  endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("rx irq without unit");
  property p_excl;
    !(tx_req_ack && rx_req_ack);
  endproperty
  a_excl: assert property (p_excl) else $error("two sources at once");
  property p_hold;
    mem.req && !mem_ack |=> mem.req && $stable(mem.addr) && $stable(mem.we);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped early");
  property p_drop;
    mem.req && mem_ack |=> !mem.req;
  endproperty
  a_drop: assert property (p_drop) else $error("request kept after ack");
  property p_quiet;
    tx_req_ack || rx_req_ack |-> !mem.req;
  endproperty
  a_quiet: assert property (p_quiet) else $error("access during ack");
  c_tx: cover property (irq_tx_done);
  c_rx: cover property (irq_rx_done);
  c_wr: cover property (mem.req && mem.we && mem_ack);
endmodule : ette_sva

bind ette_top ette_sva u_sva (.hclk(hclk), .hresetn(hresetn), .tx_req_ack(tx_req_ack),
  .rx_req_ack(rx_req_ack), .irq_tx_done(irq_tx_done), .irq_rx_done(irq_rx_done), .mem(mem),
  .mem_ack(mem_ack));

//--- verification/ette_mem_model.sv
module ette_mem_model
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Memory slave
  input wire ette_pkg::ette_mem_s mem,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // Stall control
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 100ps;
  import ette_pkg::*;
  logic [7:0] ram [0:1023];
  logic [1:0] wait_cnt;
  int acc_cnt;
  always @(posedge hclk or negedge hresetn)
  begin : serve
    logic [9:0] a;
    logic [31:0] rd;
    a = mem.addr[9:0];
    rd = 32'h0;
    if (!hresetn)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_cnt <= 2'h0;
    end
    else if (mem.req && !mem_ack && (!slow || wait_cnt == 2'h3))
    begin
      for (int i = 0; i < (1 << mem.size); i++)
      begin
        rd[8*i +: 8] = ram[a + i[9:0]];
        if (mem.we)
          ram[a + i[9:0]] <= mem.wdata[8*i +: 8];
      end
      mem_ack <= 1'b1;
      mem_rdata <= rd;
      wait_cnt <= 2'h0;
      acc_cnt <= acc_cnt + 1;
    end
    else
    begin
      // Stale data would let a late sample pass
      mem_rdata <= ~mem_rdata;
      mem_ack <= 1'b0;
      wait_cnt <= (mem.req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule : ette_mem_model

//--- verification/testbench.sv
`define CHK(a, e) \
  begin \
    total_checks++; \
    if ((a) !== (e)) \
    begin \
      fails++; \
      $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import ette_pkg::*;
  logic hclk, hresetn, hsel, hwrite, slow, tx_empty_req, rx_full_req;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, mem_rdata;
  logic hreadyout, hresp, tx_req_ack, rx_req_ack, irq_tx_done, irq_rx_done, mem_ack;
  ette_mem_s mem;
  int fails, total_checks, cycles;
  ette_top u_ette_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_empty_req(tx_empty_req),
    .rx_full_req(rx_full_req), .tx_req_ack(tx_req_ack), .rx_req_ack(rx_req_ack),
    .irq_tx_done(irq_tx_done), .irq_rx_done(irq_rx_done), .mem(mem), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  ette_mem_model u_mem (.hclk(hclk), .hresetn(hresetn), .mem(mem), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .slow(slow));
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  // Bound on the whole run, well above the few thousand cycles needed
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      results();
    end
  end
  task automatic ahb(input logic wr, input logic [31:0] a, wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr
  task automatic rdchk(input logic [31:0] a, e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    `CHK(x, e)
  endtask : rdchk
  task automatic put32(input logic [9:0] a, input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      u_mem.ram[a + i[9:0]] = v[8*i +: 8];
  endtask : put32
  function automatic logic [31:0] get32(input logic [9:0] a);
    return {u_mem.ram[a + 10'h3], u_mem.ram[a + 10'h2], u_mem.ram[a + 10'h1], u_mem.ram[a]};
  endfunction : get32
  task automatic info(input logic [9:0] v, p, input logic [31:0] w0, w1, w2, w3);
    put32(v, {22'h0, p});
    put32(p, w0);
    put32(p + 10'h4, w1);
    put32(p + 10'h8, w2);
    put32(p + 10'hc, w3);
  endtask : info
  // Single-cycle request, so a finished unit never retriggers
  task automatic unit(input logic tx, irq);
    if (tx)
      tx_empty_req <= 1'b1;
    else
      rx_full_req <= 1'b1;
    @(posedge hclk);
    tx_empty_req <= 1'b0;
    rx_full_req <= 1'b0;
    do @(posedge hclk); while ((tx ? tx_req_ack : rx_req_ack) !== 1'b1);
    `CHK(tx ? irq_tx_done : irq_rx_done, irq)
  endtask : unit
  task automatic test_regs();
    rdchk(CTRL_OFS, {24'h0, CTRL_RST});
    rdchk(ENAB_OFS, {16'h0, ENAB_RST});
    rdchk(VBASE_OFS, VBASE_RST);
    wr(CTRL_OFS, 32'hffff_ffff);
    rdchk(CTRL_OFS, {24'h0, CTRL_MASK});
    wr(VBASE_OFS, 32'h0000_0300);
    rdchk(VBASE_OFS, 32'h0000_0300);
    wr(CTRL_OFS, 32'h0);
    rdchk(32'h0000_0020, 32'h0);
    `CHK(hresp, 1'b0)
    rdchk(STAT_OFS, 32'h0);
    $display("regs done");
  endtask : test_regs
  task automatic test_tx();
    put32(10'h000, 32'ha3a2_a1a0);
    info(10'h320, 10'h340, 32'h0800_0000, 32'h0, 32'h3f0, 32'h0002_1234);
    wr(ENAB_OFS, 32'h100);
    unit(1'b1, 1'b0);
    unit(1'b1, 1'b1);
    `CHK(u_mem.ram[10'h3f0], 8'ha1)
    `CHK(get32(10'h344), 32'h2)
    `CHK(get32(10'h348), 32'h3f0)
    `CHK(get32(10'h34c), 32'h0000_1234)
    rdchk(ENAB_OFS, 32'h0);
    wr(ENAB_OFS, 32'h0);
    $display("tx done");
  endtask : test_tx
  task automatic test_rx();
    slow <= 1'b1;
    u_mem.ram[10'h3f4] = 8'h5c;
    info(10'h324, 10'h360, 32'h0008_0000, 32'h3f4, 32'h100, 32'h0001_0000);
    wr(ENAB_OFS, 32'h200);
    unit(1'b0, 1'b1);
    `CHK(u_mem.ram[10'h100], 8'h5c)
    `CHK(get32(10'h364), 32'h3f4)
    `CHK(get32(10'h368), 32'h101)
    rdchk(ENAB_OFS, 32'h0);
    wr(ENAB_OFS, 32'h0);
    slow <= 1'b0;
    $display("rx done");
  endtask : test_rx
  task automatic test_rep();
    int a0, a1;
    wr(CTRL_OFS, 32'h10);
    info(10'h320, 10'h340, 32'h4800_0000, 32'h0, 32'h3f0, 32'h0202_beef);
    wr(ENAB_OFS, 32'h100);
    a0 = u_mem.acc_cnt;
    unit(1'b1, 1'b0);
    a1 = u_mem.acc_cnt;
    unit(1'b1, 1'b0);
    `CHK(u_mem.acc_cnt - a1 < a1 - a0, 1'b1)
    `CHK(get32(10'h34c), 32'h0202_beef)
    rdchk(ENAB_OFS, 32'h100);
    wr(CTRL_OFS, 32'h0);
    wr(ENAB_OFS, 32'h0);
    $display("repeat done");
  endtask : test_rep
  task automatic test_blk();
    for (int i = 0; i < 256; i++)
      u_mem.ram[i] = 8'(i) ^ 8'h5a;
    u_mem.ram[10'h200] = 8'h77;
    info(10'h320, 10'h340, 32'h8808_0000, 32'h0, 32'h100, 32'h0000_0001);
    wr(ENAB_OFS, 32'h100);
    unit(1'b1, 1'b1);
    for (int i = 0; i < 256; i++)
      `CHK(u_mem.ram[10'h100 + i[9:0]], 8'(i) ^ 8'h5a)
    `CHK(u_mem.ram[10'h200], 8'h77)
    `CHK(get32(10'h34c), 32'h0)
    rdchk(ENAB_OFS, 32'h0);
    $display("block done");
  endtask : test_blk
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tx_empty_req = 1'b0;
    rx_full_req = 1'b0;
    slow = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_regs();
    test_tx();
    test_rx();
    test_rep();
    test_blk();
    results();
  end
endmodule : testbench
